// ==== pkg/pch_pkg.sv ====
// Constants and types shared by the configuration header register bank.
package pch_pkg;

    // ------------------------------------------------------------------
    // Register offsets in the 64-byte configuration space.
    // ------------------------------------------------------------------
    localparam logic [5:0] ID_OFF  = 6'h00;
    localparam logic [5:0] CMD_OFF = 6'h04;

    // ------------------------------------------------------------------
    // Field positions within the command and status word.
    // ------------------------------------------------------------------
    localparam int CMD_IO_BIT    = 0;
    localparam int CMD_MEM_BIT   = 1;
    localparam int CMD_SCR_LO    = 2;
    localparam int CMD_CMP_LO    = 4;
    localparam int CMD_PAR_BIT   = 6;
    localparam int CMD_STEP_BIT  = 7;
    localparam int CMD_SERR_BIT  = 8;
    localparam int STS_MDPE_BIT  = 24;
    localparam int STS_DEVSEL_LO = 25;
    localparam int STS_SERR_BIT  = 30;
    localparam int STS_PERR_BIT  = 31;

    // ------------------------------------------------------------------
    // Fixed field values and values after reset.
    // ------------------------------------------------------------------
    localparam logic [1:0]  DEVSEL_MEDIUM = 2'h1;
    localparam logic        STEP_VAL      = 1'b1;
    localparam logic        MDPE_VAL      = 1'b0;
    localparam logic [31:0] WORD_ZERO     = 32'h0000_0000;

    // Cycles from an address hit to the claim, for medium decode speed.
    localparam int DECODE_LAT = 1;

    // State of the register bank.
    typedef struct packed {
        logic        io_en;
        logic        mem_en;
        logic        par_en;
        logic        serr_en;
        logic [1:0]  scratch;
        logic [1:0]  compat;
        logic        sts_serr;
        logic        sts_perr;
        logic        io_claim;
        logic        mem_claim;
        logic        cfg_hit;
        logic [31:0] rdata;
    } pch_regs_t;

    localparam pch_regs_t REGS_RST = '0;

    // State of the parity event unit.
    typedef struct packed {
        logic serr;
    } pch_par_t;

    localparam pch_par_t PAR_RST = '0;

endpackage

// ==== pkg/pch_err_if.sv ====
// Interface between the register bank and the parity event unit.
`timescale 1ns/1ps
interface pch_err_if;
    logic par_en;
    logic serr_en;
    logic addr_perr;
    logic data_perr;
    logic serr_fire;
    logic perr_seen;

    modport ctl  (output par_en, serr_en, addr_perr, data_perr,
                  input  serr_fire, perr_seen);
    modport unit (input  par_en, serr_en, addr_perr, data_perr,
                  output serr_fire, perr_seen);
endinterface

// ==== rtl/pch_parity_unit.sv ====
// Parity event unit: system error pulse and parity-detected event.
`timescale 1ns/1ps
module pch_parity_unit (
    input  wire logic core_clk_i,
    input  wire logic rst_i,
    pch_err_if.unit   err
);

    pch_pkg::pch_par_t s_reg;
    pch_pkg::pch_par_t s_next;

    // ------------------------------------------------------------------
    // Next state.
    // ------------------------------------------------------------------

    // A system error fires only for an address parity error, and only
    // when both checking and system error reporting are enabled.
    always_comb begin
        s_next      = s_reg;
        s_next.serr = err.addr_perr & err.par_en & err.serr_en;
    end

    // State register.
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            s_reg <= pch_pkg::PAR_RST;
        end else begin
            s_reg <= s_next;
        end
    end

    // The detected flag ignores the check enable entirely.
    assign err.perr_seen = err.addr_perr | err.data_perr;
    assign err.serr_fire = s_reg.serr;

    // ------------------------------------------------------------------
    // Checks.
    // ------------------------------------------------------------------
    default clocking cb @(posedge core_clk_i);
    endclocking
    default disable iff (rst_i);

    sequence s_gated_aperr;
        err.addr_perr && err.par_en && err.serr_en;
    endsequence

    a_serr_cause: assert property (err.serr_fire |->
        $past(err.addr_perr) && $past(err.par_en) && $past(err.serr_en))
        else $error("System error fired without an address parity error.");

    a_serr_fires: assert property (s_gated_aperr |=> err.serr_fire)
        else $error("Enabled address parity error did not fire.");

    a_serr_off: assert property (!err.serr_en |=> !err.serr_fire)
        else $error("System error fired while its enable was clear.");

endmodule

// ==== rtl/pch_cfg_regs.sv ====
// Configuration header registers: identification, command and status.
`timescale 1ns/1ps
module pch_cfg_regs #(
    parameter logic [15:0] VENDOR_CODE = 16'h0ABC, // Arbitrary value.
    parameter logic [15:0] DEVICE_CODE = 16'h0DEF  // Arbitrary value.
) (
    input  wire logic        core_clk_i,
    input  wire logic        rst_i,
    input  wire logic        cfg_rd_i,
    input  wire logic        cfg_wr_i,
    input  wire logic [5:0]  cfg_addr_i,
    input  wire logic [3:0]  cfg_be_i,
    input  wire logic [31:0] cfg_wdata_i,
    output logic      [31:0] cfg_rdata_o,
    output logic             cfg_hit_o,
    input  wire logic        io_hit_i,
    input  wire logic        mem_hit_i,
    output logic             io_claim_o,
    output logic             mem_claim_o,
    input  wire logic        addr_perr_i,
    input  wire logic        data_perr_i,
    output logic             parity_report_en_o,
    output logic             serr_n_o,
    output logic             serr_oe_o
);

    // ------------------------------------------------------------------
    // Helper functions.
    // ------------------------------------------------------------------

    // Word offset of a byte address; the low two bits never select.
    function automatic logic [5:0] word_of(input logic [5:0] addr);
        word_of = {addr[5:2], 2'b00};
    endfunction

    // True when the given byte lane is enabled.
    function automatic logic lane_on(input logic [3:0] be,
                                     input int         lane);
        lane_on = be[lane];
    endfunction

    // ------------------------------------------------------------------
    // State and wiring.
    // ------------------------------------------------------------------
    pch_pkg::pch_regs_t r_reg;
    pch_pkg::pch_regs_t r_next;
    logic [31:0]        id_word;
    logic [31:0]        cmd_word;
    logic [5:0]         acc_word;
    logic               wr_cmd;

    pch_err_if err ();

    // The parity unit turns error events into the system error pulse.
    pch_parity_unit u_parity (
        .core_clk_i (core_clk_i),
        .rst_i      (rst_i),
        .err        (err)
    );

    // Enables and raw events go to the parity unit.
    assign err.par_en    = r_reg.par_en;
    assign err.serr_en   = r_reg.serr_en;
    assign err.addr_perr = addr_perr_i;
    assign err.data_perr = data_perr_i;

    // ------------------------------------------------------------------
    // Read words.
    // ------------------------------------------------------------------

    // Identification is constant and never stored.
    assign id_word = {DEVICE_CODE, VENDOR_CODE};

    // Command and status word, with fixed fields as constants.
    always_comb begin
        cmd_word                           = pch_pkg::WORD_ZERO;
        cmd_word[pch_pkg::CMD_IO_BIT]      = r_reg.io_en;
        cmd_word[pch_pkg::CMD_MEM_BIT]     = r_reg.mem_en;
        cmd_word[pch_pkg::CMD_SCR_LO +: 2] = r_reg.scratch;
        cmd_word[pch_pkg::CMD_CMP_LO +: 2] = r_reg.compat;
        cmd_word[pch_pkg::CMD_PAR_BIT]     = r_reg.par_en;
        cmd_word[pch_pkg::CMD_STEP_BIT]    = pch_pkg::STEP_VAL;
        cmd_word[pch_pkg::CMD_SERR_BIT]    = r_reg.serr_en;
        cmd_word[pch_pkg::STS_MDPE_BIT]    = pch_pkg::MDPE_VAL;
        cmd_word[pch_pkg::STS_DEVSEL_LO +: 2] = pch_pkg::DEVSEL_MEDIUM;
        cmd_word[pch_pkg::STS_SERR_BIT]    = r_reg.sts_serr;
        cmd_word[pch_pkg::STS_PERR_BIT]    = r_reg.sts_perr;
    end

    // The six address bits span exactly the 64 configuration bytes.
    assign acc_word = word_of(cfg_addr_i);
    assign wr_cmd   = cfg_wr_i && (acc_word == pch_pkg::CMD_OFF);

    // ------------------------------------------------------------------
    // Next state.
    // ------------------------------------------------------------------

    // Decode claims, register reads and writes, and status events.
    always_comb begin
        r_next         = r_reg;
        r_next.cfg_hit = 1'b0;

        // Claims come one cycle after the hit, which is medium decode.
        r_next.io_claim  = io_hit_i & r_reg.io_en;
        r_next.mem_claim = mem_hit_i & r_reg.mem_en;

        // Reads return a whole word; unmapped words read zero.
        if (cfg_rd_i) begin
            r_next.cfg_hit = (acc_word == pch_pkg::ID_OFF) ||
                             (acc_word == pch_pkg::CMD_OFF);
            case (acc_word)
                pch_pkg::ID_OFF:  r_next.rdata = id_word;
                pch_pkg::CMD_OFF: r_next.rdata = cmd_word;
                default:          r_next.rdata = pch_pkg::WORD_ZERO;
            endcase
        end

        // Writes to the identification word change nothing.
        if (cfg_wr_i) begin
            r_next.cfg_hit = (acc_word == pch_pkg::ID_OFF) || wr_cmd;
        end

        // Command byte 0: enables, scratchpad and compatibility storage.
        if (wr_cmd && lane_on(cfg_be_i, 0)) begin
            r_next.io_en   = cfg_wdata_i[pch_pkg::CMD_IO_BIT];
            r_next.mem_en  = cfg_wdata_i[pch_pkg::CMD_MEM_BIT];
            r_next.scratch = cfg_wdata_i[pch_pkg::CMD_SCR_LO +: 2];
            r_next.compat  = cfg_wdata_i[pch_pkg::CMD_CMP_LO +: 2];
            r_next.par_en  = cfg_wdata_i[pch_pkg::CMD_PAR_BIT];
        end

        // Command byte 1: system error enable.
        if (wr_cmd && lane_on(cfg_be_i, 1)) begin
            r_next.serr_en = cfg_wdata_i[pch_pkg::CMD_SERR_BIT];
        end

        // Status byte 3: a one clears a flag, a zero leaves it.
        if (wr_cmd && lane_on(cfg_be_i, 3)) begin
            if (cfg_wdata_i[pch_pkg::STS_SERR_BIT]) begin
                r_next.sts_serr = 1'b0;
            end
            if (cfg_wdata_i[pch_pkg::STS_PERR_BIT]) begin
                r_next.sts_perr = 1'b0;
            end
        end

        // Events are applied last so a set beats a same-cycle clear.
        if (err.serr_fire) begin
            r_next.sts_serr = 1'b1;
        end
        if (err.perr_seen) begin
            r_next.sts_perr = 1'b1;
        end
    end

    // State register; reset restores every field.
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            r_reg <= pch_pkg::REGS_RST;
        end else begin
            r_reg <= r_next;
        end
    end

    // ------------------------------------------------------------------
    // Outputs.
    // ------------------------------------------------------------------

    // Data and claim outputs come straight from the state register.
    assign cfg_rdata_o        = r_reg.rdata;
    assign cfg_hit_o          = r_reg.cfg_hit;
    assign io_claim_o         = r_reg.io_claim;
    assign mem_claim_o        = r_reg.mem_claim;
    assign parity_report_en_o = r_reg.par_en;

    // The error pin is open drain: it only ever pulls low.
    assign serr_oe_o = err.serr_fire;
    assign serr_n_o  = ~err.serr_fire;

    // ------------------------------------------------------------------
    // Checks.
    // ------------------------------------------------------------------
    default clocking cb @(posedge core_clk_i);
    endclocking
    default disable iff (rst_i);

    sequence s_read_id;
        cfg_rd_i && (word_of(cfg_addr_i) == pch_pkg::ID_OFF);
    endsequence

    sequence s_read_cmd;
        cfg_rd_i && (word_of(cfg_addr_i) == pch_pkg::CMD_OFF);
    endsequence

    sequence s_write_scratch;
        cfg_wr_i && (word_of(cfg_addr_i) == pch_pkg::CMD_OFF) && cfg_be_i[0];
    endsequence

    sequence s_clear_perr;
        cfg_wr_i && (word_of(cfg_addr_i) == pch_pkg::CMD_OFF) &&
        cfg_be_i[3] && cfg_wdata_i[pch_pkg::STS_PERR_BIT];
    endsequence

    a_id_value: assert property (s_read_id |=>
        cfg_rdata_o == {DEVICE_CODE, VENDOR_CODE})
        else $error("Identification word read back wrong.");

    a_fixed_bits: assert property (s_read_cmd |=>
        cfg_rdata_o[pch_pkg::CMD_STEP_BIT] == 1'b1)
        else $error("Stepping bit did not read one.");

    a_mdpe_zero: assert property (s_read_cmd |=>
        cfg_rdata_o[pch_pkg::STS_MDPE_BIT] == 1'b0)
        else $error("Reserved status bit did not read zero.");

    a_devsel_code: assert property (s_read_cmd |=>
        cfg_rdata_o[pch_pkg::STS_DEVSEL_LO +: 2] == 2'h1)
        else $error("Decode timing field did not read 01.");

    a_io_gate: assert property (io_claim_o |-> $past(r_reg.io_en))
        else $error("I/O access claimed while I/O space was disabled.");

    a_io_claim: assert property (io_hit_i && r_reg.io_en |=>
        io_claim_o)
        else $error("Enabled I/O hit was not claimed one cycle later.");

    a_mem_gate: assert property (mem_claim_o |->
        $past(mem_hit_i) && $past(r_reg.mem_en))
        else $error("Memory claim without an enabled memory hit.");

    a_scratch_back: assert property (s_write_scratch ##1 s_read_cmd |=>
        cfg_rdata_o[pch_pkg::CMD_SCR_LO +: 2] ==
        $past(cfg_wdata_i[pch_pkg::CMD_SCR_LO +: 2], 2))
        else $error("Scratchpad did not return the last value written.");

    a_serr_flag: assert property (serr_oe_o |=> r_reg.sts_serr)
        else $error("System error driven without setting its flag.");

    a_perr_flag: assert property (addr_perr_i || data_perr_i |=>
        r_reg.sts_perr)
        else $error("Parity error did not set the detected flag.");

    a_perr_w1c: assert property ((s_clear_perr and
        (!addr_perr_i && !data_perr_i)) |=> !r_reg.sts_perr)
        else $error("Writing one did not clear the parity flag.");

    a_no_sw_set: assert property ($rose(r_reg.sts_perr) |->
        $past(addr_perr_i) || $past(data_perr_i))
        else $error("Parity flag rose without a parity event.");

endmodule

// ==== verif/pch_host_model.sv ====
// Configuration software model that drives the register access strobes.
`timescale 1ns/1ps
module pch_host_model (
    input  wire logic        core_clk_i,
    input  wire logic [31:0] cfg_rdata_i,
    input  wire logic        cfg_hit_i,
    output logic             cfg_rd_o,
    output logic             cfg_wr_o,
    output logic      [5:0]  cfg_addr_o,
    output logic      [3:0]  cfg_be_o,
    output logic      [31:0] cfg_wdata_o
);
    // -----------------------------------------------------------------
    // Bus idles with no strobe.
    // -----------------------------------------------------------------
    initial begin
        cfg_rd_o    = 1'b0;
        cfg_wr_o    = 1'b0;
        cfg_addr_o  = 6'h00;
        cfg_be_o    = 4'h0;
        cfg_wdata_o = 32'h0000_0000;
    end

    // One-cycle read; data and hit are taken one cycle after the strobe.
    task automatic cfg_read(input logic [5:0] a, output logic [31:0] d,
                            output logic h);
        @(posedge core_clk_i);
        cfg_rd_o   <= 1'b1;
        cfg_addr_o <= a;
        @(posedge core_clk_i);
        cfg_rd_o   <= 1'b0;
        #1;
        d = cfg_rdata_i;
        h = cfg_hit_i;
    endtask

    // Writable command and status positions; all others are sent as zero.
    localparam logic [31:0] CMD_WR_MASK = 32'hC000_017F;

    // One-cycle write; the command word keeps reserved and read-only
    // positions at zero, though the stepping bit 7 and the decode timing bit 25 read back as one.
    task automatic cfg_write(input logic [5:0] a, input logic [3:0] b,
                             input logic [31:0] d);
        @(posedge core_clk_i);
        cfg_wr_o    <= 1'b1;
        cfg_addr_o  <= a;
        cfg_be_o    <= b;
        cfg_wdata_o <= (a == pch_pkg::CMD_OFF) ? (d & CMD_WR_MASK) : d;
        @(posedge core_clk_i);
        cfg_wr_o    <= 1'b0;
    endtask

    // A write and a read of the same word on back-to-back edges; the
    // read data is taken one cycle after the read strobe.
    task automatic cfg_write_read(input logic [5:0]   a,
                                  input logic [3:0]   b,
                                  input logic [31:0]  wd,
                                  output logic [31:0] d);
        @(posedge core_clk_i);
        cfg_wr_o    <= 1'b1;
        cfg_addr_o  <= a;
        cfg_be_o    <= b;
        cfg_wdata_o <= (a == pch_pkg::CMD_OFF) ? (wd & CMD_WR_MASK) : wd;
        @(posedge core_clk_i);
        cfg_wr_o    <= 1'b0;
        cfg_rd_o    <= 1'b1;
        @(posedge core_clk_i);
        cfg_rd_o    <= 1'b0;
        #1;
        d = cfg_rdata_i;
    endtask
endmodule

// ==== verif/pch_cfg_regs_tb.sv ====
// Self-checking testbench of the configuration header register bank.
`timescale 1ns/1ps
module pch_cfg_regs_tb;
    localparam logic [15:0] VEN     = 16'h0123; // Arbitrary value.
    localparam logic [15:0] DEV     = 16'h0456; // Arbitrary value.
    localparam logic [31:0] CMD_RST = 32'h0200_0080;

    typedef struct packed {
        logic [3:0]  be;
        logic [31:0] wd;
        logic [31:0] exp;
    } pch_row_t;

    logic        core_clk_i, rst_i, io_hit, mem_hit, aperr, dperr;
    logic        cfg_rd, cfg_wr, hit, io_claim, mem_claim;
    logic        par_en, serr_n, serr_oe, h;
    logic [5:0]  addr;
    logic [3:0]  be;
    logic [31:0] wdata, rdata, d;
    int          error_cnt, samples_checked, cyc;
    pch_row_t    rows [4];

    pch_cfg_regs #(.VENDOR_CODE(VEN), .DEVICE_CODE(DEV)) DUT (
        .core_clk_i(core_clk_i), .rst_i(rst_i), .cfg_rd_i(cfg_rd),
        .cfg_wr_i(cfg_wr), .cfg_addr_i(addr), .cfg_be_i(be),
        .cfg_wdata_i(wdata), .cfg_rdata_o(rdata), .cfg_hit_o(hit),
        .io_hit_i(io_hit), .mem_hit_i(mem_hit), .io_claim_o(io_claim),
        .mem_claim_o(mem_claim), .addr_perr_i(aperr),
        .data_perr_i(dperr), .parity_report_en_o(par_en),
        .serr_n_o(serr_n), .serr_oe_o(serr_oe));

    pch_host_model HOST (
        .core_clk_i(core_clk_i), .cfg_rdata_i(rdata), .cfg_hit_i(hit),
        .cfg_rd_o(cfg_rd), .cfg_wr_o(cfg_wr), .cfg_addr_o(addr),
        .cfg_be_o(be), .cfg_wdata_o(wdata));

    // -----------------------------------------------------------------
    // Clock, timeout and reporting.
    // -----------------------------------------------------------------
    initial begin
        core_clk_i = 1'b0;
        forever #5 core_clk_i = ~core_clk_i;
    end

    // A hang ends the run as a failure.
    always @(posedge core_clk_i) begin
        cyc++;
        if (cyc == 5000) begin
            error_cnt++;
            give_verdict();
        end
    end

    task automatic check(input string n, input logic [31:0] s,
                         input logic [31:0] e);
        samples_checked++;
        if (s !== e) begin
            error_cnt++;
            $display("BAD %s expected %h seen %h", n, e, s);
        end
    endtask

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    // Pulses the parity error inputs for one cycle, then settles.
    task automatic pulse(input logic a, input logic dp);
        @(posedge core_clk_i);
        aperr <= a;
        dperr <= dp;
        @(posedge core_clk_i);
        aperr <= 1'b0;
        dperr <= 1'b0;
        #1;
    endtask

    // Reads the command and status word and compares it.
    task automatic cmd_is(input string n, input logic [31:0] e);
        HOST.cfg_read(pch_pkg::CMD_OFF, d, h);
        check(n, d, e);
    endtask

    // -----------------------------------------------------------------
    // Main sequence.
    // -----------------------------------------------------------------
    initial begin
        rst_i   = 1'b1;
        io_hit  = 1'b0;
        mem_hit = 1'b0;
        aperr   = 1'b0;
        dperr   = 1'b0;
        rows[0] = '{4'h1, 32'h0000_007F, 32'h0200_00FF};
        rows[1] = '{4'h2, 32'h0000_0100, 32'h0200_01FF};
        rows[2] = '{4'h1, 32'h0000_0000, 32'h0200_0180};
        rows[3] = '{4'h3, 32'h0000_014C, 32'h0200_01CC};
        repeat (20) @(posedge core_clk_i);
        rst_i <= 1'b0;

        // Values after reset.
        HOST.cfg_read(pch_pkg::ID_OFF, d, h);
        check("id", d, {DEV, VEN});
        check("id_hit", {31'h0, h}, 32'h0000_0001);
        cmd_is("cmd_rst", CMD_RST);

        // Command writes and read-back from the row table.
        foreach (rows[i]) begin
            HOST.cfg_write(pch_pkg::CMD_OFF, rows[i].be, rows[i].wd);
            cmd_is("cmd_row", rows[i].exp);
            check("par_en", {31'h0, par_en}, {31'h0, rows[i].exp[6]});
        end

        // A read straight after a write returns the new scratchpad value.
        HOST.cfg_write_read(pch_pkg::CMD_OFF, 4'h1, 32'h0000_0004, d);
        check("scr_b2b", d, 32'h0200_0184);

        // Decode enables, with compatibility bits set to show no effect.
        for (int k = 0; k < 4; k++) begin
            HOST.cfg_write(pch_pkg::CMD_OFF, 4'h1, 32'h0000_0030 | k);
            @(posedge core_clk_i);
            io_hit  <= 1'b1;
            mem_hit <= 1'b1;
            @(posedge core_clk_i);
            io_hit  <= 1'b0;
            mem_hit <= 1'b0;
            #1;
            check("io_claim", {31'h0, io_claim}, k & 1);
            check("mem_claim", {31'h0, mem_claim}, k >> 1);
        end

        // Address parity with reporting and system error enabled.
        HOST.cfg_write(pch_pkg::CMD_OFF, 4'h3, 32'h0000_0140);
        pulse(1'b1, 1'b0);
        check("serr_oe", {31'h0, serr_oe}, 32'h0000_0001);
        check("serr_n", {31'h0, serr_n}, 32'h0000_0000);
        cmd_is("flags_set", 32'hC200_01C0);
        HOST.cfg_write(pch_pkg::CMD_OFF, 4'h8, 32'h0000_0000);
        cmd_is("w0_keeps", 32'hC200_01C0);
        HOST.cfg_write(pch_pkg::CMD_OFF, 4'h8, 32'hC000_0000);
        cmd_is("w1_clears", 32'h0200_01C0);
        HOST.cfg_write(pch_pkg::CMD_OFF, 4'h8, 32'hC000_0000);
        cmd_is("no_sw_set", 32'h0200_01C0);

        // Data parity never drives the system error.
        pulse(1'b0, 1'b1);
        check("serr_dp", {31'h0, serr_oe}, 32'h0000_0000);
        cmd_is("dp_flag", 32'h8200_01C0);
        HOST.cfg_write(pch_pkg::CMD_OFF, 4'h8, 32'hC000_0000);

        // Parity checking off: no system error, bit 31 still set.
        HOST.cfg_write(pch_pkg::CMD_OFF, 4'h1, 32'h0000_0000);
        pulse(1'b1, 1'b0);
        check("serr_p6", {31'h0, serr_oe}, 32'h0000_0000);
        cmd_is("p6_flag", 32'h8200_0180);
        HOST.cfg_write(pch_pkg::CMD_OFF, 4'h8, 32'hC000_0000);

        // System error enable off: no system error.
        HOST.cfg_write(pch_pkg::CMD_OFF, 4'h3, 32'h0000_0040);
        pulse(1'b1, 1'b0);
        check("serr_p8", {31'h0, serr_oe}, 32'h0000_0000);
        cmd_is("p8_flag", 32'h8200_00C0);

        // Unmapped words and writes to the identification word.
        HOST.cfg_write(6'h08, 4'hF, 32'hFFFF_FFFF);
        HOST.cfg_read(6'h08, d, h);
        check("unmap_rd", d, 32'h0000_0000);
        check("unmap_hit", {31'h0, h}, 32'h0000_0000);
        HOST.cfg_read(6'h3C, d, h);
        check("top_rd", d, 32'h0000_0000);
        HOST.cfg_write(pch_pkg::ID_OFF, 4'hF, 32'hFFFF_FFFF);
        HOST.cfg_read(pch_pkg::ID_OFF, d, h);
        check("id_fixed", d, {DEV, VEN});

        // Reset in mid-run restores every field.
        @(posedge core_clk_i);
        rst_i <= 1'b1;
        @(posedge core_clk_i);
        rst_i <= 1'b0;
        cmd_is("cmd_rerst", CMD_RST);
        give_verdict();
    end
endmodule
